// >>> hw/bcd_cfg_pkg.sv
// Shared constants for the BCD output configuration decoder
package bcd_cfg_pkg;
    localparam int         DIGITS          = 11;
    localparam int         CODE_W          = 44;
    localparam logic [3:0] DIGIT_COUNT_MAX = 4'hB;

    // Data kind selection codes, digits one to three
    localparam logic [2:0] SEL_AXIS1  = 3'h1;
    localparam logic [2:0] SEL_AXIS2  = 3'h2;
    localparam logic [2:0] SEL_ADDSUB = 3'h3;
    localparam logic [2:0] SEL_MAX    = 3'h4;
    localparam logic [2:0] SEL_MIN    = 3'h5;
    localparam logic [2:0] SEL_PP     = 3'h6;

    // Two-choice digits: 1 positive or first choice, 2 negative or second
    localparam logic [3:0] CHOICE_ONE = 4'h1;
    localparam logic [3:0] CHOICE_TWO = 4'h2;

    // Output mode codes, digit seven
    localparam logic [2:0] MODE_CONSTANT   = 3'h1;
    localparam logic [2:0] MODE_LATCH_BCD  = 3'h2;
    localparam logic [2:0] MODE_LATCH_BOTH = 3'h3;
    localparam logic [2:0] MODE_TRISTATE   = 3'h4;
    localparam logic [2:0] MODE_HIGH_SPEED = 3'h5;

    localparam logic [4:0] REFRESH_NONE = 5'h00;
    localparam logic [7:0] REFRESH_MAX  = 8'h14;

    // Reset values
    localparam logic [2:0] RST_SEL_ONE   = SEL_ADDSUB;
    localparam logic [2:0] RST_SEL_TWO   = SEL_MIN;
    localparam logic [2:0] RST_SEL_THREE = SEL_MAX;
    localparam logic       RST_DATA_NEG  = 1'b0;
    localparam logic       RST_SIGN_NEG  = 1'b1;
    localparam logic       RST_READY_NEG = 1'b1;
    localparam logic [2:0] RST_MODE      = MODE_CONSTANT;

    // Manual kind and axis codes
    localparam logic [1:0] KIND_CURRENT = 2'h0;
    localparam logic [1:0] KIND_MAX     = 2'h1;
    localparam logic [1:0] KIND_MIN     = 2'h2;
    localparam logic [1:0] KIND_PP      = 2'h3;
    localparam logic [1:0] AXIS_ADDSUB  = 2'h2;

    // Confirmation hold time
    localparam int CONFIRM_TIME_MS = 2000;
    localparam int CLOCK_HZ        = 50000000;
    localparam int CONFIRM_CYCLES  = CONFIRM_TIME_MS * (CLOCK_HZ / 1000);

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b001,
        ST_AXIS    = 3'b010,
        ST_CONFIRM = 3'b100
    } entry_state_t;
endpackage

// >>> hw/bcd_code_checker.sv
// Digit range check of an eleven-digit setup code
`timescale 1ns/1ps
module bcd_code_checker (
    input  wire logic [43:0] setup_code,
    output logic             code_ok
);
    logic [3:0] dig [11];
    logic [7:0] refresh_sum;

    genvar gi;
    generate
        for (gi = 0; gi < 11; gi++) begin : g_dig
            assign dig[gi] = setup_code[43 - 4 * gi -: 4];
        end
    endgenerate

    assign refresh_sum = 8'({4'h0, dig[7]} * 8'h0A) + {4'h0, dig[8]};

    always_comb begin
        code_ok = 1'b1;
        for (int i = 0; i < 3; i++) begin
            if (dig[i] < 4'h1 || dig[i] > 4'h6) begin
                code_ok = 1'b0;
            end
        end
        for (int i = 3; i < 6; i++) begin
            if (dig[i] != bcd_cfg_pkg::CHOICE_ONE && dig[i] != bcd_cfg_pkg::CHOICE_TWO) begin
                code_ok = 1'b0;
            end
        end
        if (dig[6] < 4'h1 || dig[6] > 4'h5) begin
            code_ok = 1'b0;
        end
        if (dig[7] > 4'h9 || dig[8] > 4'h9 || refresh_sum > bcd_cfg_pkg::REFRESH_MAX) begin
            code_ok = 1'b0;
        end
        for (int i = 9; i < 11; i++) begin
            if (dig[i] != bcd_cfg_pkg::CHOICE_ONE && dig[i] != bcd_cfg_pkg::CHOICE_TWO) begin
                code_ok = 1'b0;
            end
        end
    end
endmodule

// >>> hw/bcd_output_config_decoder.sv
// Setup code decoder and request-driven data selector for the BCD output
//
// Contract
// - Digits one-three pick data per request line; four-six set data/sign/ready polarity.
// - Digit seven picks output mode, codes one to five.
// - Digits eight-nine hold refresh delay; high-speed mode forces it to zero.
// - The single BCD output carries the data configured for the asserted request.
// - After reset: line one add/sub current, line two minimum, three maximum.
// - Choosing current value needs a further axis choice before the entry completes.
// - A committed setting shows steadily about two seconds, then menu returns.
// - Abort keeps stored settings and, only while idle, discards the partial code.
`timescale 1ns/1ps
module bcd_output_config_decoder #(
    parameter int VALUE_W        = 32,
    parameter int CONFIRM_CYCLES = bcd_cfg_pkg::CONFIRM_CYCLES
) (
    input  wire logic               clock,
    input  wire logic               nrst,
    input  wire logic [3:0]         digit_in,
    input  wire logic               digit_strobe,
    input  wire logic               commit_key,
    input  wire logic               abort_key,
    input  wire logic [1:0]         manual_line,
    input  wire logic [1:0]         manual_kind,
    input  wire logic               manual_enter,
    input  wire logic [1:0]         manual_axis,
    input  wire logic               axis_enter,
    input  wire logic [2:0]         output_request,
    input  wire logic [VALUE_W-1:0] axis1_value,
    input  wire logic [VALUE_W-1:0] axis2_value,
    input  wire logic [VALUE_W-1:0] addsub_value,
    input  wire logic [VALUE_W-1:0] max_value,
    input  wire logic [VALUE_W-1:0] min_value,
    input  wire logic [VALUE_W-1:0] pp_value,
    output logic [2:0]              request_one_selection,
    output logic [2:0]              request_two_selection,
    output logic [2:0]              request_three_selection,
    output logic                    data_logic_negative,
    output logic                    sign_logic_negative,
    output logic                    ready_logic_negative,
    output logic [2:0]              output_mode,
    output logic [4:0]              refresh_delay,
    output logic                    power_on_data_output,
    output logic                    alarm_hold_previous,
    output logic [VALUE_W-1:0]      bcd_out,
    output logic                    request_active,
    output logic                    display_steady,
    output logic                    menu_return,
    output logic                    code_rejected,
    output logic [3:0]              digits_entered
);
    localparam logic [31:0] TIMER_LAST = 32'(CONFIRM_CYCLES - 1);

    bcd_cfg_pkg::entry_state_t state_reg, state_next;
    logic [43:0]        code_reg, code_next;
    logic [3:0]         count_reg, count_next;
    logic [31:0]        timer_reg, timer_next;
    logic [1:0]         pend_line_reg, pend_line_next;
    logic [2:0]         sel_reg [3];
    logic [2:0]         sel_next [3];
    logic               dneg_reg, dneg_next, sneg_reg, sneg_next, rneg_reg, rneg_next;
    logic [2:0]         mode_reg, mode_next;
    logic [4:0]         refresh_reg, refresh_next;
    logic               pwr_reg, pwr_next, alarm_reg, alarm_next;
    logic [VALUE_W-1:0] bcd_reg, bcd_next;
    logic               active_reg, active_next;
    logic               steady_reg, steady_next, ret_reg, ret_next, rej_reg, rej_next;
    logic [2:0]         req_meta_reg, req_sync_reg;
    logic [3:0]         dig [11];
    logic               code_ok, idle, commit_ok, reject_now, manual_ok, axis_ok, manual_apply;
    logic [1:0]         apply_line;
    logic [2:0]         apply_code, chosen_sel;
    logic [VALUE_W-1:0] chosen_value;
    logic [7:0]         refresh_sum;

    bcd_code_checker u_checker (
        .setup_code (code_reg),
        .code_ok    (code_ok)
    );

    genvar gi;
    generate
        for (gi = 0; gi < 11; gi++) begin : g_dig
            assign dig[gi] = code_reg[43 - 4 * gi -: 4];
        end
    endgenerate

    assign idle        = (state_reg == bcd_cfg_pkg::ST_IDLE);
    assign commit_ok   = idle && commit_key && !abort_key && code_ok && count_reg == bcd_cfg_pkg::DIGIT_COUNT_MAX;
    assign reject_now  = idle && commit_key && !abort_key && !commit_ok;
    assign manual_ok   = idle && manual_enter && !commit_key && !abort_key && manual_line != 2'h0;
    assign axis_ok     = state_reg == bcd_cfg_pkg::ST_AXIS && axis_enter && !abort_key
                         && manual_axis <= bcd_cfg_pkg::AXIS_ADDSUB;
    assign refresh_sum = 8'({4'h0, dig[7]} * 8'h0A) + {4'h0, dig[8]};

    always_comb begin
        manual_apply = 1'b0;
        apply_line   = manual_line;
        apply_code   = bcd_cfg_pkg::SEL_MAX;
        if (manual_ok && manual_kind != bcd_cfg_pkg::KIND_CURRENT) begin
            manual_apply = 1'b1;
            case (manual_kind)
                bcd_cfg_pkg::KIND_MAX: apply_code = bcd_cfg_pkg::SEL_MAX;
                bcd_cfg_pkg::KIND_MIN: apply_code = bcd_cfg_pkg::SEL_MIN;
                default:               apply_code = bcd_cfg_pkg::SEL_PP;
            endcase
        end else if (axis_ok) begin
            manual_apply = 1'b1;
            apply_line   = pend_line_reg;
            apply_code   = bcd_cfg_pkg::SEL_AXIS1 + {1'b0, manual_axis};
        end
    end

    // Entry state machine and confirmation timer
    always_comb begin
        state_next     = state_reg;
        timer_next     = 32'h0000_0000;
        pend_line_next = pend_line_reg;
        steady_next    = 1'b0;
        ret_next       = 1'b0;
        rej_next       = reject_now;
        case (state_reg)
            bcd_cfg_pkg::ST_IDLE: begin
                if (commit_ok || manual_apply) begin
                    state_next  = bcd_cfg_pkg::ST_CONFIRM;
                    steady_next = 1'b1;
                end else if (manual_ok) begin
                    state_next     = bcd_cfg_pkg::ST_AXIS;
                    pend_line_next = manual_line;
                end
            end
            bcd_cfg_pkg::ST_AXIS: begin
                if (abort_key) begin
                    state_next = bcd_cfg_pkg::ST_IDLE;
                end else if (axis_ok) begin
                    state_next  = bcd_cfg_pkg::ST_CONFIRM;
                    steady_next = 1'b1;
                end
            end
            bcd_cfg_pkg::ST_CONFIRM: begin
                if (timer_reg >= TIMER_LAST) begin
                    state_next = bcd_cfg_pkg::ST_IDLE;
                    ret_next   = 1'b1;
                end else begin
                    timer_next  = timer_reg + 32'h0000_0001;
                    steady_next = 1'b1;
                end
            end
            default: state_next = bcd_cfg_pkg::ST_IDLE;
        endcase
    end

    // Code buffer; keys are ignored while a confirmation is shown
    always_comb begin
        code_next  = code_reg;
        count_next = count_reg;
        if (idle && (abort_key || commit_key)) begin
            code_next  = 44'h000_0000_0000;
            count_next = 4'h0;
        end else if (idle && digit_strobe && count_reg < bcd_cfg_pkg::DIGIT_COUNT_MAX) begin
            code_next  = {code_reg[39:0], digit_in};
            count_next = count_reg + 4'h1;
        end
    end

    // Settings update
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            sel_next[i] = sel_reg[i];
        end
        dneg_next    = dneg_reg;
        sneg_next    = sneg_reg;
        rneg_next    = rneg_reg;
        mode_next    = mode_reg;
        refresh_next = refresh_reg;
        pwr_next     = pwr_reg;
        alarm_next   = alarm_reg;
        if (commit_ok) begin
            for (int i = 0; i < 3; i++) begin
                sel_next[i] = dig[i][2:0];
            end
            dneg_next  = (dig[3] == bcd_cfg_pkg::CHOICE_TWO);
            sneg_next  = (dig[4] == bcd_cfg_pkg::CHOICE_TWO);
            rneg_next  = (dig[5] == bcd_cfg_pkg::CHOICE_TWO);
            mode_next  = dig[6][2:0];
            refresh_next = (dig[6][2:0] == bcd_cfg_pkg::MODE_HIGH_SPEED) ? bcd_cfg_pkg::REFRESH_NONE
                                                                          : refresh_sum[4:0];
            pwr_next   = (dig[9] == bcd_cfg_pkg::CHOICE_TWO);
            alarm_next = (dig[10] == bcd_cfg_pkg::CHOICE_TWO);
        end else if (manual_apply) begin
            sel_next[apply_line - 2'h1] = apply_code;
        end
    end

    always_comb begin
        // Overlapping requests are unsupported; lowest line wins to stay defined
        chosen_sel = sel_reg[0];
        if (!req_sync_reg[0] && req_sync_reg[1]) begin
            chosen_sel = sel_reg[1];
        end else if (!req_sync_reg[0] && !req_sync_reg[1]) begin
            chosen_sel = sel_reg[2];
        end
        case (chosen_sel)
            bcd_cfg_pkg::SEL_AXIS1:  chosen_value = axis1_value;
            bcd_cfg_pkg::SEL_AXIS2:  chosen_value = axis2_value;
            bcd_cfg_pkg::SEL_ADDSUB: chosen_value = addsub_value;
            bcd_cfg_pkg::SEL_MAX:    chosen_value = max_value;
            bcd_cfg_pkg::SEL_MIN:    chosen_value = min_value;
            default:                 chosen_value = pp_value;
        endcase
        active_next = |req_sync_reg;
        bcd_next    = active_next ? chosen_value : bcd_reg;
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            state_reg     <= bcd_cfg_pkg::ST_IDLE;
            timer_reg     <= 32'h0000_0000;
            pend_line_reg <= 2'h1;
            steady_reg    <= 1'b0;
            ret_reg       <= 1'b0;
            rej_reg       <= 1'b0;
            code_reg      <= 44'h000_0000_0000;
            count_reg     <= 4'h0;
            sel_reg[0]    <= bcd_cfg_pkg::RST_SEL_ONE;
            sel_reg[1]    <= bcd_cfg_pkg::RST_SEL_TWO;
            sel_reg[2]    <= bcd_cfg_pkg::RST_SEL_THREE;
            dneg_reg      <= bcd_cfg_pkg::RST_DATA_NEG;
            sneg_reg      <= bcd_cfg_pkg::RST_SIGN_NEG;
            rneg_reg      <= bcd_cfg_pkg::RST_READY_NEG;
            mode_reg      <= bcd_cfg_pkg::RST_MODE;
            refresh_reg   <= bcd_cfg_pkg::REFRESH_NONE;
            pwr_reg       <= 1'b0;
            alarm_reg     <= 1'b0;
            bcd_reg       <= '0;
            active_reg    <= 1'b0;
            req_meta_reg  <= 3'h0;
            req_sync_reg  <= 3'h0;
        end else begin
            state_reg     <= state_next;
            timer_reg     <= timer_next;
            pend_line_reg <= pend_line_next;
            steady_reg    <= steady_next;
            ret_reg       <= ret_next;
            rej_reg       <= rej_next;
            code_reg      <= code_next;
            count_reg     <= count_next;
            sel_reg       <= sel_next;
            dneg_reg      <= dneg_next;
            sneg_reg      <= sneg_next;
            rneg_reg      <= rneg_next;
            mode_reg      <= mode_next;
            refresh_reg   <= refresh_next;
            pwr_reg       <= pwr_next;
            alarm_reg     <= alarm_next;
            bcd_reg       <= bcd_next;
            active_reg    <= active_next;
            req_meta_reg  <= output_request;
            req_sync_reg  <= req_meta_reg;
        end
    end

    assign request_one_selection   = sel_reg[0];
    assign request_two_selection   = sel_reg[1];
    assign request_three_selection = sel_reg[2];
    assign data_logic_negative     = dneg_reg;
    assign sign_logic_negative     = sneg_reg;
    assign ready_logic_negative    = rneg_reg;
    assign output_mode             = mode_reg;
    assign refresh_delay           = refresh_reg;
    assign power_on_data_output    = pwr_reg;
    assign alarm_hold_previous     = alarm_reg;
    assign bcd_out                 = bcd_reg;
    assign request_active          = active_reg;
    assign display_steady          = steady_reg;
    assign menu_return             = ret_reg;
    assign code_rejected           = rej_reg;
    assign digits_entered          = count_reg;

    a_code_selections: assert property (@(posedge clock) disable iff (!nrst)
        commit_ok |=> request_two_selection == $past(dig[1][2:0]) && data_logic_negative == ($past(dig[3]) == 4'h2))
        else $error("selection or polarity not taken from code");
    a_mode_digit: assert property (@(posedge clock) disable iff (!nrst)
        commit_ok |=> output_mode == $past(dig[6][2:0]))
        else $error("output mode not taken from digit seven");
    a_refresh_forced: assert property (@(posedge clock) disable iff (!nrst)
        output_mode == bcd_cfg_pkg::MODE_HIGH_SPEED |-> refresh_delay == 5'h00 && refresh_delay <= 5'h14)
        else $error("refresh delay wrong for mode");
    a_request_data: assert property (@(posedge clock) disable iff (!nrst)
        (req_sync_reg == 3'h2 && request_two_selection == 3'h5) |=> bcd_out == $past(min_value) && request_active)
        else $error("request two data not driven");
    a_reset_defaults: assert property (@(posedge clock) disable iff (!nrst)
        $rose(nrst) |-> request_one_selection == 3'h3 && request_two_selection == 3'h5 && request_three_selection == 3'h4)
        else $error("reset selections wrong");
    a_axis_pending: assert property (@(posedge clock) disable iff (!nrst)
        (manual_ok && manual_kind == 2'h0) |=> state_reg == bcd_cfg_pkg::ST_AXIS && $stable(request_one_selection)
        && !display_steady)
        else $error("current value completed without axis");
    a_confirm_hold: assert property (@(posedge clock) disable iff (!nrst)
        (commit_ok || manual_apply) |=> display_steady [*8])
        else $error("confirmation not held steady");
    a_confirm_end: assert property (@(posedge clock) disable iff (!nrst)
        $rose(menu_return) |-> $past(timer_reg) == TIMER_LAST && !display_steady)
        else $error("menu return at wrong time");
    a_abort_keeps: assert property (@(posedge clock) disable iff (!nrst)
        (idle && abort_key) |=> digits_entered == 4'h0 && $stable(output_mode) && $stable(request_three_selection))
        else $error("abort altered settings or kept code");
    a_reject_keeps: assert property (@(posedge clock) disable iff (!nrst)
        reject_now |=> code_rejected && $stable(output_mode) && $stable(request_one_selection) && !display_steady)
        else $error("bad code not rejected");

    c_commit: cover property (@(posedge clock) disable iff (!nrst) commit_ok);
    c_axis_entry: cover property (@(posedge clock) disable iff (!nrst) axis_ok);
    c_menu_return: cover property (@(posedge clock) disable iff (!nrst) menu_return);
    c_reject: cover property (@(posedge clock) disable iff (!nrst) reject_now);
endmodule

// >>> sim/bcd_reader.sv
// Controller model that raises one output request line at a time
`timescale 1ns/1ps
module bcd_reader (
    input  wire logic [0:0] clock,
    input  wire logic [1:0] line_cmd,
    output logic      [2:0] output_request
);
    initial output_request = 3'h0;
    always @(posedge clock) begin
        #1 output_request = (line_cmd == 2'h0) ? 3'h0 : (3'h1 << (line_cmd - 2'h1));
    end
endmodule

// >>> sim/testbench.sv
// Self-checking bench for the BCD output configuration decoder
`timescale 1ns/1ps
module testbench;
    typedef struct packed { logic [43:0] code; logic [21:0] cfg; } row_t;
    logic        clock = 1'b0, nrst = 1'b0;
    logic [3:0]  digit_in = 4'h0;
    logic        digit_strobe = 1'b0, commit_key = 1'b0, abort_key = 1'b0;
    logic        manual_enter = 1'b0, axis_enter = 1'b0;
    logic [1:0]  line_cmd = 2'h0, manual_line = 2'h0, manual_kind = 2'h0, manual_axis = 2'h0;
    logic [31:0] vals [1:6];
    logic [2:0]  output_request, sel1, sel2, sel3, mode;
    logic        dneg, sneg, rneg, pwr, alm, req_act, steady, menu_ret, rej;
    logic [4:0]  refresh;
    logic [3:0]  count;
    logic [31:0] bcd_out;
    logic [21:0] saved;
    int          fails = 0, checked = 0, cycles = 0;
    wire  [21:0] cfg = {sel1, sel2, sel3, dneg, sneg, rneg, mode, refresh, pwr, alm};
    // Every mode and every data kind appears at least once
    // both axes present
    row_t rows [5] = '{
        '{44'h12311210511, {3'h1, 3'h2, 3'h3, 3'h1, 3'h1, 5'h05, 2'h0}},
        '{44'h45622251222, {3'h4, 3'h5, 3'h6, 3'h7, 3'h5, 5'h00, 2'h3}},
        '{44'h64122142012, {3'h6, 3'h4, 3'h1, 3'h6, 3'h4, 5'h14, 2'h1}},
        '{44'h11111130111, {3'h1, 3'h1, 3'h1, 3'h0, 3'h3, 5'h01, 2'h0}},
        '{44'h22211121111, {3'h2, 3'h2, 3'h2, 3'h0, 3'h2, 5'h0B, 2'h0}}};

    bcd_output_config_decoder #(.CONFIRM_CYCLES(16)) bcd_output_config_decoder_inst (
        .clock(clock), .nrst(nrst), .digit_in(digit_in), .digit_strobe(digit_strobe),
        .commit_key(commit_key), .abort_key(abort_key), .manual_line(manual_line),
        .manual_kind(manual_kind), .manual_enter(manual_enter), .manual_axis(manual_axis),
        .axis_enter(axis_enter), .output_request(output_request), .axis1_value(vals[1]),
        .axis2_value(vals[2]), .addsub_value(vals[3]), .max_value(vals[4]), .min_value(vals[5]),
        .pp_value(vals[6]), .request_one_selection(sel1), .request_two_selection(sel2),
        .request_three_selection(sel3), .data_logic_negative(dneg), .sign_logic_negative(sneg),
        .ready_logic_negative(rneg), .output_mode(mode), .refresh_delay(refresh),
        .power_on_data_output(pwr), .alarm_hold_previous(alm), .bcd_out(bcd_out),
        .request_active(req_act), .display_steady(steady), .menu_return(menu_ret),
        .code_rejected(rej), .digits_entered(count));

    bcd_reader bcd_reader_inst (.clock(clock), .line_cmd(line_cmd), .output_request(output_request));

    always #10 clock = ~clock;

    task automatic end_sim;
        $display("Comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Run is about five hundred cycles; this ceiling only catches a hang
    always @(posedge clock) begin
        cycles++;
        if (cycles == 8000) begin
            fails++;
            $display("BAD %0t cycle limit reached", $time);
            end_sim();
        end
    end

    task automatic check(input logic [43:0] seen, input logic [43:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic key_in(input logic [43:0] code, input int n);
        for (int i = 10; i > 10 - n; i--) begin
            digit_in = code[i*4 +: 4];
            digit_strobe = 1'b1;
            tick(1);
        end
        digit_strobe = 1'b0;
    endtask

    task automatic enter_code(input logic [43:0] code);
        key_in(code, 11);
        commit_key = 1'b1;
        tick(1);
        commit_key = 1'b0;
    endtask

    // Hold length is approximate, so a one-cycle slack either way
    task automatic hold_end;
        int n;
        n = 0;
        while (steady === 1'b1 && n < 40) begin
            n++;
            tick(1);
        end
        check(44'(n >= 15 && n <= 17), 44'h1);
        check(menu_ret, 1'b1);
    endtask

    task automatic request(input logic [1:0] line, input logic [2:0] sel);
        line_cmd = line;
        tick(5);
        check(bcd_out, vals[sel]);
        check(req_act, 1'b1);
        line_cmd = 2'h0;
        tick(5);
        check(req_act, 1'b0);
    endtask

    task automatic manual(input logic [1:0] line, input logic [1:0] kind);
        manual_line = line;
        manual_kind = kind;
        manual_enter = 1'b1;
        tick(1);
        manual_enter = 1'b0;
    endtask

    task automatic axis(input logic [1:0] ax);
        manual_axis = ax;
        axis_enter = 1'b1;
        tick(1);
        axis_enter = 1'b0;
    endtask

    initial begin
        for (int k = 1; k <= 6; k++) vals[k] = 32'h11111111 * k;
        tick(12);
        nrst = 1'b1;
        check(cfg, {3'h3, 3'h5, 3'h4, 3'h3, 3'h1, 5'h00, 2'h0});
        request(2'h1, 3'h3);
        request(2'h2, 3'h5);
        request(2'h3, 3'h4);
        foreach (rows[r]) begin
            vals[1] = vals[1] + 32'h1;
            enter_code(rows[r].code);
            check(cfg, rows[r].cfg);
            hold_end();
            request(2'h1, rows[r].cfg[21:19]);
            request(2'h2, rows[r].cfg[18:16]);
            request(2'h3, rows[r].cfg[15:13]);
        end
        saved = cfg;
        key_in(44'h12311210511, 5);
        check(count, 4'h5);
        abort_key = 1'b1;
        tick(1);
        abort_key = 1'b0;
        tick(1);
        check(count, 4'h0);
        check(cfg, saved);
        enter_code(44'h12311260511);
        check(rej, 1'b1);
        check(cfg, saved);
        enter_code(44'h12311212111);
        check(rej, 1'b1);
        check(cfg, saved);
        manual(2'h2, bcd_cfg_pkg::KIND_CURRENT);
        tick(2);
        check(sel2, saved[18:16]);
        check(steady, 1'b0);
        axis(2'h0);
        check(sel2, bcd_cfg_pkg::SEL_AXIS1);
        hold_end();
        manual(2'h3, bcd_cfg_pkg::KIND_MAX);
        check(sel3, bcd_cfg_pkg::SEL_MAX);
        hold_end();
        manual(2'h1, bcd_cfg_pkg::KIND_MIN);
        check(sel1, bcd_cfg_pkg::SEL_MIN);
        hold_end();
        manual(2'h2, bcd_cfg_pkg::KIND_PP);
        check(sel2, bcd_cfg_pkg::SEL_PP);
        hold_end();
        // Axis code three refused, then abort drops the pending entry
        manual(2'h1, bcd_cfg_pkg::KIND_CURRENT);
        axis(2'h3);
        check(steady, 1'b0);
        abort_key = 1'b1;
        tick(1);
        abort_key = 1'b0;
        axis(2'h1);
        check(sel1, bcd_cfg_pkg::SEL_MIN);
        check(steady, 1'b0);
        manual(2'h3, bcd_cfg_pkg::KIND_CURRENT);
        axis(2'h1);
        check(sel3, bcd_cfg_pkg::SEL_AXIS2);
        hold_end();
        // Mid-run reset must restore the defaults
        nrst = 1'b0;
        tick(3);
        nrst = 1'b1;
        check(cfg, {3'h3, 3'h5, 3'h4, 3'h3, 3'h1, 5'h00, 2'h0});
        request(2'h1, 3'h3);
        end_sim();
    end
endmodule
